// >>> src/output_word_ctl.sv
// Top of the output control word block: latch, mode decode, pin drivers.
// Assumes the charge-pump gain bit and test levels come from core_clk logic.
`timescale 1ns/1ps

// Contract
// RULE1: Latch enable rise with address 01 copies data field into the word.
// RULE2: Word holds output mode in bits 15..18, powerdown select at bit 19.
// RULE3: General-purpose mode drives first pin at the level of bit 15.
// RULE4: General-purpose mode drives second pin at the level of bit 16.
// RULE5: General-purpose mode only when fastlock and test bits are both zero.
// RULE6: Fastlock mode when bit 18 is one and test bit is zero.
// RULE7: Fastlock with high gain pulls first pin actively low.
// RULE8: Fastlock without high gain leaves first pin off, high impedance.
// RULE9: Fastlock ignores level bits; second pin stays high impedance.
// RULE10: Test bit 17 set selects test mode, overriding other modes.
// RULE11: Each serial bit is shifted in on the serial clock rising edge.
// RULE12: Host sends MSB first, address bits last before latch enable.
// RULE13: Latch rise with other addresses leaves word and pins unchanged.
module output_word_ctl (
    input wire logic core_clk,                  // 10 MHz core clock
    input wire logic nrst,                      // Async reset, active low
    input wire logic ser_data,                  // Serial data pin
    input wire logic ser_clk,                   // Serial clock pin
    input wire logic latch_enable,              // Latch enable pin
    input wire logic charge_pump_high_gain_bit, // Gain bit, core domain
    input wire logic test_level0,               // Test mode level, pin 0
    input wire logic test_level1,               // Test mode level, pin 1
    output logic first_output_pin_o,            // First pin level
    output logic first_output_pin_oe_n,         // First pin drive, low=on
    output logic second_output_pin_o,           // Second pin level
    output logic second_output_pin_oe_n,        // Second pin drive, low=on
    output logic powerdown_select_bit,          // Powerdown mode select
    output serial_word_pkg::pin_mode_e pin_mode // Current pin mode
);
    import serial_word_pkg::*;

    // ------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------
    shift_link_if link ();

    serial_shifter u_shifter (
        .core_clk(core_clk),
        .nrst(nrst),
        .ser_data(ser_data),
        .ser_clk(ser_clk),
        .latch_enable(latch_enable),
        .link(link)
    );

    // ------------------------------------------------------------
    // Output pin control word
    // ------------------------------------------------------------
    logic [WORD_W-1:0] output_pin_control_word_reg;
    logic [WORD_W-1:0] output_pin_control_word_next;
    logic [ADDR_W-1:0] latch_addr;
    logic [WORD_W-1:0] latch_data;
    logic word_hit;

    // Address sits in the two bits clocked last
    assign latch_addr = link.shift_word[ADDR_W-1:0]; // see RULE12
    assign latch_data = link.shift_word[SHIFT_W-1:ADDR_W];
    assign word_hit = link.latch_pulse && (latch_addr == ADDR_OUT_WORD);
    // Other addresses belong to other words and are simply dropped
    assign output_pin_control_word_next = word_hit ?
        latch_data : output_pin_control_word_reg; // see RULE1 see RULE13

    // Word register; no documented reset so zero gives quiet outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            output_pin_control_word_reg <= WORD_RESET;
        end else begin
            output_pin_control_word_reg <= output_pin_control_word_next;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic level0_bit;
    logic level1_bit;
    logic test_bit;
    logic fast_bit;
    pin_mode_e mode_sel;

    // Only bits 15..19 are used; the rest are don't care
    assign level0_bit = output_pin_control_word_reg[LEVEL0_BIT]; // see RULE2
    assign level1_bit = output_pin_control_word_reg[LEVEL1_BIT];
    assign test_bit = output_pin_control_word_reg[TEST_BIT];
    assign fast_bit = output_pin_control_word_reg[FAST_BIT];
    // Test has priority, then fastlock, then general purpose
    assign mode_sel = test_bit ? MODE_TEST : // see RULE10
        (fast_bit ? MODE_FAST : MODE_GP); // see RULE5 see RULE6

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic pin0_next;
    logic pin0_oe_n_next;
    logic pin1_next;
    logic pin1_oe_n_next;

    // Output enables are low while driving
    always_comb begin
        pin0_next = 1'b0;
        pin0_oe_n_next = 1'b1;
        pin1_next = 1'b0;
        pin1_oe_n_next = 1'b1;
        unique case (mode_sel)
            MODE_GP: begin
                pin0_next = level0_bit;   // see RULE3
                pin0_oe_n_next = 1'b0;
                pin1_next = level1_bit;   // see RULE4
                pin1_oe_n_next = 1'b0;
            end
            MODE_FAST: begin
                // Pin 0 switches the damping resistor to ground
                pin0_next = 1'b0; // see RULE7
                pin0_oe_n_next = !charge_pump_high_gain_bit; // see RULE8
                pin1_next = 1'b0;
                pin1_oe_n_next = 1'b1;    // see RULE9
            end
            MODE_TEST: begin
                pin0_next = test_level0;
                pin0_oe_n_next = 1'b0;
                pin1_next = test_level1;
                pin1_oe_n_next = 1'b0;
            end
        endcase
    end

    // Registered pins keep glitches off the package outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first_output_pin_o <= 1'b0;
            first_output_pin_oe_n <= 1'b0;
            second_output_pin_o <= 1'b0;
            second_output_pin_oe_n <= 1'b0;
        end else begin
            first_output_pin_o <= pin0_next;
            first_output_pin_oe_n <= pin0_oe_n_next;
            second_output_pin_o <= pin1_next;
            second_output_pin_oe_n <= pin1_oe_n_next;
        end
    end

    // Status mirrors, one cycle behind the word like the pins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            powerdown_select_bit <= 1'b0;
            pin_mode <= MODE_GP;
        end else begin
            powerdown_select_bit <= output_pin_control_word_reg[POWERDOWN_BIT];
            pin_mode <= mode_sel;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence hit_seq;
        link.latch_pulse && latch_addr == ADDR_OUT_WORD;
    endsequence

    sequence miss_seq;
        link.latch_pulse && latch_addr != ADDR_OUT_WORD;
    endsequence

    word_load_a: assert property ( // see RULE1
        hit_seq |=> output_pin_control_word_reg == $past(latch_data))
        else $error("word not loaded on matching latch");

    word_hold_a: assert property ( // see RULE13
        miss_seq |=> $stable(output_pin_control_word_reg) ##1
            $stable(first_output_pin_oe_n) && $stable(second_output_pin_oe_n))
        else $error("word or pins changed on foreign address");

    gp_pin0_a: assert property ( // see RULE3
        !test_bit && !fast_bit |=> !first_output_pin_oe_n &&
            first_output_pin_o == $past(level0_bit))
        else $error("first pin does not follow level bit");

    gp_pin1_a: assert property ( // see RULE4
        !test_bit && !fast_bit |=> !second_output_pin_oe_n &&
            second_output_pin_o == $past(level1_bit))
        else $error("second pin does not follow level bit");

    mode_select_a: assert property ( // see RULE5
        ##1 (pin_mode == MODE_GP) == ($past(!test_bit) && $past(!fast_bit)))
        else $error("general mode flag wrong");

    fast_enter_a: assert property ( // see RULE6
        fast_bit && !test_bit |=> pin_mode == MODE_FAST)
        else $error("fastlock mode not entered");

    fast_drive_a: assert property ( // see RULE7
        fast_bit && !test_bit && charge_pump_high_gain_bit |=>
            !first_output_pin_oe_n && !first_output_pin_o)
        else $error("first pin not pulled low in acquisition");

    fast_off_a: assert property ( // see RULE8
        fast_bit && !test_bit && !charge_pump_high_gain_bit |=>
            first_output_pin_oe_n)
        else $error("first pin not released after acquisition");

    fast_pin1_a: assert property ( // see RULE9
        fast_bit && !test_bit |=> second_output_pin_oe_n)
        else $error("second pin driven in fastlock");

    test_over_a: assert property ( // see RULE10
        test_bit |=> pin_mode == MODE_TEST &&
            first_output_pin_o == $past(test_level0) &&
            second_output_pin_o == $past(test_level1))
        else $error("test mode does not override");

endmodule

// >>> src/serial_word_pkg.sv
// Package of shared constants for the serial output control word block.
// Assumes a single core clock domain; imported by every design module.
package serial_word_pkg;

    // ------------------------------------------------------------
    // Shift register layout
    // ------------------------------------------------------------
    localparam int SHIFT_W = 24;
    localparam int ADDR_W = 2;
    localparam int WORD_W = 22;
    localparam logic [ADDR_W-1:0] ADDR_OUT_WORD = 2'h1;

    // ------------------------------------------------------------
    // Output control word fields (data field numbering)
    // ------------------------------------------------------------
    localparam int LEVEL0_BIT = 15;
    localparam int LEVEL1_BIT = 16;
    localparam int TEST_BIT = 17;
    localparam int FAST_BIT = 18;
    localparam int POWERDOWN_BIT = 19;
    localparam logic [WORD_W-1:0] WORD_RESET = 22'h000000;

    // ------------------------------------------------------------
    // Synchroniser depth and pin modes
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        MODE_GP = 3'b001,
        MODE_FAST = 3'b010,
        MODE_TEST = 3'b100
    } pin_mode_e;

endpackage

// >>> src/shift_link_if.sv
// Interface carrying the assembled shift word and its latch pulse.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps

interface shift_link_if;
    import serial_word_pkg::*;

    logic [SHIFT_W-1:0] shift_word; // Current shift register contents
    logic latch_pulse;              // One cycle on latch enable rise

    modport src (output shift_word, output latch_pulse);
    modport dst (input shift_word, input latch_pulse);
endinterface

// >>> src/serial_shifter.sv
// Three-wire serial front end: synchronisers, shift register, latch edge.
// Assumes the serial clock is much slower than core_clk (800 ns vs 100 ns).
`timescale 1ns/1ps

module serial_shifter (
    input wire logic core_clk,      // Core clock
    input wire logic nrst,          // Async reset, active low
    input wire logic ser_data,      // Serial data pin
    input wire logic ser_clk,       // Serial clock pin
    input wire logic latch_enable,  // Latch enable pin
    shift_link_if.src link          // Word and latch pulse out
);
    import serial_word_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] data_sync_reg;
    logic [SYNC_STAGES-1:0] clk_sync_reg;
    logic [SYNC_STAGES-1:0] latch_sync_reg;
    logic clk_prev_reg;
    logic latch_prev_reg;
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] shift_next;
    logic clk_rise;
    logic latch_rise;

    // Data goes through the same depth as the clock so they stay aligned
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data_sync_reg <= '0;
            clk_sync_reg <= '0;
            latch_sync_reg <= '0;
        end else begin
            data_sync_reg <= {data_sync_reg[0], ser_data};
            clk_sync_reg <= {clk_sync_reg[0], ser_clk};
            latch_sync_reg <= {latch_sync_reg[0], latch_enable};
        end
    end

    // ------------------------------------------------------------
    // Edge detection and shifting
    // ------------------------------------------------------------
    assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
    assign latch_rise = latch_sync_reg[1] & ~latch_prev_reg;
    // MSB first, so new bits enter at the bottom
    assign shift_next = clk_rise ?
        {shift_reg[SHIFT_W-2:0], data_sync_reg[1]} : shift_reg; // see RULE11

    // Shift register and edge history
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clk_prev_reg <= 1'b0;
            latch_prev_reg <= 1'b0;
            shift_reg <= '0;
        end else begin
            clk_prev_reg <= clk_sync_reg[1];
            latch_prev_reg <= latch_sync_reg[1];
            shift_reg <= shift_next;
        end
    end

    assign link.shift_word = shift_reg;
    assign link.latch_pulse = latch_rise;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    shift_in_a: assert property (@(posedge core_clk) // see RULE11
        disable iff (!nrst)
        clk_rise |=> shift_reg[0] == $past(data_sync_reg[1]) &&
            shift_reg[SHIFT_W-1:1] == $past(shift_reg[SHIFT_W-2:0]))
        else $error("serial bit not shifted in on clock rise");

    shift_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !clk_rise |=> $stable(shift_reg))
        else $error("shift register moved without a clock rise");

endmodule

// >>> verif/host_serial_model.sv
// Host-side model of the three-wire serial load path.
// Assumes core_clk paces it; the serial clock is 8 core cycles (800 ns).
`timescale 1ns/1ps

module host_serial_model (
    input wire logic core_clk, // Core clock, paces the host
    output logic ser_data,     // Serial data to device
    output logic ser_clk,      // Serial clock, idle low
    output logic latch_enable  // Latch enable, idle low
);
    // ------------------------------------------------------------
    // Idle state: clock stands still low outside frames
    // ------------------------------------------------------------
    initial begin
        ser_data = 1'b0;
        ser_clk = 1'b0;
        latch_enable = 1'b0;
    end

    // Half a serial period, changes land on the core falling edge
    task automatic half_period();
        repeat (4) @(negedge core_clk);
    endtask

    // One frame; data moves at the clock fall, well clear of the rise
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin // Oldest bit first
            ser_data = w[i];
            half_period();
            ser_clk = 1'b1; // Device takes the bit here
            half_period();
            ser_clk = 1'b0;
        end
        ser_data = ~w[0]; // Line no longer shows the last bit
        half_period();
        latch_enable = 1'b1; // Address is the last pair sent
        half_period();
        latch_enable = 1'b0;
        half_period();
    endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the output control word block.
// Assumes the host model above and the design package are compiled first.
`timescale 1ns/1ps

module tb_top;
    import serial_word_pkg::*;

    logic core_clk;
    logic nrst;
    logic gain;
    logic tl0;
    logic tl1;
    wire logic ser_data;
    wire logic ser_clk;
    wire logic latch_enable;
    logic o0, oe0_n, o1, oe1_n, pwdn;
    logic [2:0] mode;
    int n_mismatch = 0;
    int total_checks = 0;
    // Pin view: mode, powerdown, pin0 level/enable, pin1 level/enable
    wire logic [7:0] pins = {mode, pwdn, o0, oe0_n, o1, oe1_n};

    output_word_ctl output_word_ctl_inst (
        .core_clk(core_clk), .nrst(nrst), .ser_data(ser_data),
        .ser_clk(ser_clk), .latch_enable(latch_enable),
        .charge_pump_high_gain_bit(gain), .test_level0(tl0),
        .test_level1(tl1), .first_output_pin_o(o0),
        .first_output_pin_oe_n(oe0_n), .second_output_pin_o(o1),
        .second_output_pin_oe_n(oe1_n), .powerdown_select_bit(pwdn),
        .pin_mode(mode)
    );

    host_serial_model host_serial_model_inst (
        .core_clk(core_clk), .ser_data(ser_data), .ser_clk(ser_clk),
        .latch_enable(latch_enable)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // About 15 frames of 204 cycles; three times that is a hang
    initial begin
        #1000000;
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end

    function automatic logic [23:0] mk(input logic f, t, b1, b0, pd,
                                       input logic [1:0] a);
        return {2'h0, pd, f, t, b1, b0, 15'h0000, a};
    endfunction

    function automatic logic [7:0] ex(input logic [2:0] m,
                                      input logic pd, l0, e0, l1, e1);
        return {m, pd, l0, e0, l1, e1};
    endfunction

    task automatic send(input logic [23:0] w);
        host_serial_model_inst.send_word(w);
    endtask

    // Masked compare; masked bits are pins nobody drives
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input logic [7:0] mask);
        total_checks++;
        if ((seen & mask) !== (exp & mask)) begin
            n_mismatch++;
            $display("mismatch at %0t ns: seen %h expected %h",
                     $time, seen & mask, exp & mask);
        end
    endtask

    task automatic settle();
        repeat (3) @(negedge core_clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        gain = 1'b0;
        tl0 = 1'b0;
        tl1 = 1'b0;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        check(pins, ex(MODE_GP, 0, 0, 0, 0, 0), 8'hFF);
        $display("test reset done");
        // Every level pair, powerdown both ways, frames back to back
        for (int k = 0; k < 8; k++) begin
            send(mk(0, 0, k[1], k[0], k[2], 2'h1));
            check(pins, ex(MODE_GP, k[2], k[0], 0, k[1], 0),
                  8'hFF);
        end
        $display("test general purpose done");
        // Other addresses must not disturb the word
        for (int a = 0; a < 4; a++) begin
            if (a != 1) begin
                send(mk(1, 1, 0, 0, 0, a[1:0]));
                check(pins, ex(MODE_GP, 1, 1, 0, 1, 0), 8'hFF);
            end
        end
        $display("test ignored address done");
        // Fastlock with level bits set, which must be ignored
        gain = 1'b1;
        send(mk(1, 0, 1, 1, 0, 2'h1));
        check(pins, ex(MODE_FAST, 0, 0, 0, 0, 1),
              8'hFD);
        gain = 1'b0;
        settle();
        check(pins, ex(MODE_FAST, 0, 0, 1, 0, 1), 8'hF5);
        gain = 1'b1;
        settle();
        check(pins, ex(MODE_FAST, 0, 0, 0, 0, 1), 8'hFD);
        $display("test fastlock done");
        // Test bit over fastlock, then test bit alone
        send(mk(1, 1, 0, 0, 0, 2'h1));
        for (int k = 0; k < 4; k++) begin
            tl0 = k[0];
            tl1 = k[1];
            settle();
            check(pins, ex(MODE_TEST, 0, k[0], 0, k[1], 0),
                  8'hFF);
        end
        tl0 = 1'b0;
        tl1 = 1'b0;
        send(mk(0, 1, 1, 1, 0, 2'h1));
        check(pins, ex(MODE_TEST, 0, 0, 0, 0, 0), 8'hFF);
        $display("test production mode done");
        // Both mode bits cleared again returns to general purpose
        send(mk(0, 0, 0, 1, 0, 2'h1));
        check(pins, ex(MODE_GP, 0, 1, 0, 0, 0), 8'hFF);
        $display("test return to general purpose done");
        conclude();
    end
endmodule
